// >>> rtl/vwo_pkg.sv
package vwo_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] VWO_OFS_DISPCFG = 8'h04;
  localparam logic [7:0] VWO_OFS_XPOS = 8'h08;
  localparam logic [7:0] VWO_OFS_YPOS = 8'h0C;
  localparam logic [7:0] VWO_OFS_SCALE = 8'h10;
  localparam logic [7:0] VWO_OFS_KEY = 8'h14;
  localparam logic [7:0] VWO_OFS_MASK = 8'h18;
  localparam logic [7:0] VWO_OFS_MIXCTL = 8'h4C;
  localparam logic [31:0] VWO_RST_ZERO = 32'h00000000;
  localparam logic [31:0] VWO_RST_MIXCTL = 32'h00060000;
  // ---------------------------------------------------------------
  // Display configuration and mixer control bits
  // ---------------------------------------------------------------
  localparam int VWO_B_CRT_RUN = 0;
  localparam int VWO_B_HS_EN = 1;
  localparam int VWO_B_VS_EN = 2;
  localparam int VWO_B_DAC_BL = 3;
  localparam int VWO_B_PWR_REQ = 6;
  localparam int VWO_B_PNL_OE = 7;
  localparam int VWO_B_HS_POL = 8;
  localparam int VWO_B_VS_POL = 9;
  localparam int VWO_B_KEY_SRC = 20;
  localparam int VWO_B_SEQ_LO = 17;
  localparam int VWO_B_PWR_FLAG = 27;
  localparam int VWO_B_CSC = 10;
  localparam int VWO_B_GVSEL = 13;
  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int VWO_XW = 12;
  localparam int VWO_YW = 11;
  localparam int VWO_SW = 14;
  localparam int VWO_KW = 24;
  localparam int VWO_HI_LO = 16;
  localparam int VWO_SEQ_W = 3;
  localparam int VWO_FRAC = 13;
  localparam logic [VWO_SW-1:0] VWO_SCALE_UNITY = 14'h2000;
  localparam int VWO_PWR_STEPS = 3;
endpackage

// >>> rtl/vwo_scale_if.sv
`timescale 1ns/1ns
interface vwo_scale_if;
  import vwo_pkg::*;
  logic restart;
  logic advance;
  logic [VWO_SW-1:0] step;
  logic [VWO_XW-1:0] srcIdx;
  logic [VWO_FRAC-1:0] phase;
  modport ctl(output restart, output advance, output step,
              input srcIdx, input phase);
  modport acc(input restart, input advance, input step,
              output srcIdx, output phase);
endinterface

// >>> rtl/vwo_scale_acc.sv
`timescale 1ns/1ns
module vwo_scale_acc (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Control and result
  vwo_scale_if.acc s
);
  import vwo_pkg::*;
  logic [VWO_XW+VWO_FRAC-1:0] acc_q;
  logic [VWO_XW+VWO_FRAC-1:0] acc_d;
  // Source position advances by step/8192 per destination unit.
  assign acc_d = s.restart ? '0 :
                 s.advance ? acc_q + (VWO_XW+VWO_FRAC)'(s.step) : acc_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) acc_q <= '0;
    else if (ce) acc_q <= acc_d;
  end
  assign s.srcIdx = acc_q[VWO_XW+VWO_FRAC-1:VWO_FRAC];
  assign s.phase = acc_q[VWO_FRAC-1:0];
endmodule

// >>> rtl/vwo_overlay_ctrl.sv
`timescale 1ns/1ns
// Contract
// - Horizontal sync polarity selects idle and active level.
// - Panel output off: data blanked, power ignored.
// - Panel output on: zero until powered up.
// - Power request edges start up/down sequences.
// - DAC blank bit zero blanks always.
// - Vertical sync enable gates vertical sync.
// - Horizontal sync enable gates horizontal sync.
// - CRT run bit zero resets CRT logic.
// - Window horizontal end bits 27:16, exclusive.
// - Window horizontal begin bits 11:0, inclusive.
// - Vertical begin bits 10:0, lines from sync.
// - Vertical end is exclusive.
// - Vertical step is field over 8192.
// - Horizontal step is field over 8192.
// - Key select 0: graphics equals masked key.
// - Key select 1: video differs from key.
// - YUV compare when conversion and select zero.
// - Zero mask bits ignored in compare.
// - Power steps spaced by frame delay field.
// - Power flag changes only at sequence end.
module vwo_overlay_ctrl #(
  parameter int XW = vwo_pkg::VWO_XW,
  parameter int YW = vwo_pkg::VWO_YW
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Register port
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  // Timing from display controller (same clock)
  input wire logic hsyncIn,
  input wire logic vsyncIn,
  input wire logic blankIn,
  // Pixel streams
  input wire logic [vwo_pkg::VWO_KW-1:0] gfxPixel,
  input wire logic [vwo_pkg::VWO_KW-1:0] vidPixel,
  // CRT outputs
  output logic crtHsync,
  output logic crtVsync,
  output logic crtDacBlank,
  output logic [vwo_pkg::VWO_KW-1:0] mixPixel,
  // Flat panel outputs
  output logic [vwo_pkg::VWO_KW-1:0] panelData,
  output logic panelDataEn,
  output logic [vwo_pkg::VWO_PWR_STEPS-1:0] panelPowerCtl,
  // Scaler source position and YUV key flag
  output logic [XW-1:0] srcX,
  output logic [XW-1:0] srcY,
  output logic keyAsYuv
);
  import vwo_pkg::*;

  if (XW != VWO_XW || YW != VWO_YW) begin : g_chk
    $error("vwo_overlay_ctrl: widths must match register fields");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] cfg_q, xpos_q, ypos_q, scale_q, key_q, mask_q, mix_q;
  logic wrCfg, wrX, wrY, wrS, wrK, wrM, wrMix;
  assign wrCfg = regWr && regAddr == VWO_OFS_DISPCFG;
  assign wrX = regWr && regAddr == VWO_OFS_XPOS;
  assign wrY = regWr && regAddr == VWO_OFS_YPOS;
  assign wrS = regWr && regAddr == VWO_OFS_SCALE;
  assign wrK = regWr && regAddr == VWO_OFS_KEY;
  assign wrM = regWr && regAddr == VWO_OFS_MASK;
  assign wrMix = regWr && regAddr == VWO_OFS_MIXCTL;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= VWO_RST_ZERO;
      xpos_q <= VWO_RST_ZERO;
      ypos_q <= VWO_RST_ZERO;
      scale_q <= VWO_RST_ZERO;
      key_q <= VWO_RST_ZERO;
      mask_q <= VWO_RST_ZERO;
      mix_q <= VWO_RST_MIXCTL;
    end else if (ce) begin
      if (wrCfg) cfg_q <= regWdata;
      if (wrX) xpos_q <= regWdata;
      if (wrY) ypos_q <= regWdata;
      if (wrS) scale_q <= regWdata;
      if (wrK) key_q <= regWdata;
      if (wrM) mask_q <= regWdata;
      if (wrMix) mix_q <= regWdata;
    end
  end

  logic crtRun, hsEn, vsEn, dacBlEn, pwrReq, pnlOe, hsPol, vsPol, keySrc;
  logic [VWO_SEQ_W-1:0] seqDelay;
  logic [XW-1:0] winHBegin, winHEnd;
  logic [YW-1:0] winVBegin, winVEnd;
  logic [VWO_SW-1:0] hStep, vStep;
  logic [VWO_KW-1:0] keyVal, keyMask;
  assign crtRun = cfg_q[VWO_B_CRT_RUN];
  assign hsEn = cfg_q[VWO_B_HS_EN];
  assign vsEn = cfg_q[VWO_B_VS_EN];
  assign dacBlEn = cfg_q[VWO_B_DAC_BL];
  assign pwrReq = cfg_q[VWO_B_PWR_REQ];
  assign pnlOe = cfg_q[VWO_B_PNL_OE];
  assign hsPol = cfg_q[VWO_B_HS_POL];
  assign vsPol = cfg_q[VWO_B_VS_POL];
  assign keySrc = cfg_q[VWO_B_KEY_SRC];
  assign seqDelay = cfg_q[VWO_B_SEQ_LO +: VWO_SEQ_W];
  assign winHEnd = xpos_q[VWO_HI_LO +: XW];
  assign winHBegin = xpos_q[XW-1:0];
  assign winVEnd = ypos_q[VWO_HI_LO +: YW];
  assign winVBegin = ypos_q[YW-1:0];
  assign vStep = scale_q[VWO_HI_LO +: VWO_SW];
  assign hStep = scale_q[VWO_SW-1:0];
  assign keyVal = key_q[VWO_KW-1:0];
  assign keyMask = mask_q[VWO_KW-1:0];

  // Power flag is status only; written values of that bit are dropped.
  logic pwrOn_q;
  logic [31:0] rdNext;
  always_comb begin
    rdNext = '0;
    unique case (regAddr)
      VWO_OFS_DISPCFG: begin
        rdNext = cfg_q;
        rdNext[VWO_B_PWR_FLAG] = pwrOn_q;
      end
      VWO_OFS_XPOS: rdNext = xpos_q;
      VWO_OFS_YPOS: rdNext = ypos_q;
      VWO_OFS_SCALE: rdNext = scale_q;
      VWO_OFS_KEY: rdNext = key_q;
      VWO_OFS_MASK: rdNext = mask_q;
      VWO_OFS_MIXCTL: rdNext = mix_q;
      default: rdNext = '0;
    endcase
  end

  // Read data leaves a flop, so a read answers one cycle after its address.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) regRdata <= '0;
    else if (ce) regRdata <= rdNext;
  end

  // ---------------------------------------------------------------
  // CRT counters, held in reset while the run bit is low
  // ---------------------------------------------------------------
  logic hs_q, vs_q;
  logic [XW-1:0] hCnt_q;
  logic [YW-1:0] vCnt_q;
  logic hsRise, vsRise;
  assign hsRise = hsyncIn && !hs_q;
  assign vsRise = vsyncIn && !vs_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      hCnt_q <= '0;
      vCnt_q <= '0;
    end else if (ce) begin
      hs_q <= hsyncIn;
      vs_q <= vsyncIn;
      if (!crtRun) begin
        hCnt_q <= '0;
        vCnt_q <= '0;
      end else begin
        hCnt_q <= hsRise ? '0 : hCnt_q + 1'b1;
        if (vsRise) vCnt_q <= '0;
        else if (hsRise) vCnt_q <= vCnt_q + 1'b1;
      end
    end
  end

  // Begin inclusive, end exclusive on both axes.
  logic inH, inV, inWin;
  assign inH = hCnt_q >= winHBegin && hCnt_q < winHEnd;
  assign inV = vCnt_q >= winVBegin && vCnt_q < winVEnd;
  assign inWin = crtRun && inH && inV;

  // ---------------------------------------------------------------
  // Upscale accumulators
  // ---------------------------------------------------------------
  vwo_scale_if hIf();
  vwo_scale_if vIf();
  assign hIf.restart = !crtRun || hsRise;
  assign hIf.advance = inWin;
  assign hIf.step = hStep;
  assign vIf.restart = !crtRun || vsRise;
  assign vIf.advance = hsRise && inV;
  assign vIf.step = vStep;
  vwo_scale_acc u_hacc (.clk(clk), .arst_n(arst_n), .ce(ce), .s(hIf));
  vwo_scale_acc u_vacc (.clk(clk), .arst_n(arst_n), .ce(ce), .s(vIf));

  // ---------------------------------------------------------------
  // Key compare
  // ---------------------------------------------------------------
  logic gfxMatch, vidMatch, showVideo, yuvKey;
  assign gfxMatch = ((gfxPixel ^ keyVal) & keyMask) == '0;
  assign vidMatch = ((vidPixel ^ keyVal) & keyMask) == '0;
  assign showVideo = inWin && (keySrc ? !vidMatch : gfxMatch);
  assign yuvKey = !mix_q[VWO_B_CSC] && !mix_q[VWO_B_GVSEL];

  // ---------------------------------------------------------------
  // Panel power sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PS_OFF, PS_UP, PS_ON, PS_DOWN} vwo_pwr_e;
  vwo_pwr_e pst_q, pst_d;
  logic pwrReq_q;
  logic [VWO_SEQ_W-1:0] frm_q;
  logic [1:0] stp_q;
  logic [VWO_PWR_STEPS-1:0] ctl_q;
  logic stepDue, seqDone, reqUp, reqDn;
  logic seqBusy;
  logic [VWO_SEQ_W:0] frmNext, dlyWide;
  assign reqUp = pnlOe && pwrReq && !pwrReq_q;
  assign reqDn = pnlOe && !pwrReq && pwrReq_q;
  // A step lands on the vsync that completes the programmed frame count,
  // so a delay of zero behaves like a delay of one frame.
  assign seqBusy = pst_q == PS_UP || pst_q == PS_DOWN;
  assign frmNext = {1'b0, frm_q} + 1'b1;
  assign dlyWide = {1'b0, seqDelay};
  assign stepDue = seqBusy && vsRise && frmNext >= dlyWide;
  assign seqDone = stepDue && stp_q == 2'(VWO_PWR_STEPS - 1);
  always_comb begin
    pst_d = pst_q;
    unique case (pst_q)
      PS_OFF: if (reqUp) pst_d = PS_UP;
      PS_UP: if (reqDn) pst_d = PS_DOWN;
             else if (seqDone) pst_d = PS_ON;
      PS_ON: if (reqDn) pst_d = PS_DOWN;
      PS_DOWN: if (reqUp) pst_d = PS_UP;
               else if (seqDone) pst_d = PS_OFF;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pst_q <= PS_OFF;
      pwrReq_q <= 1'b0;
      frm_q <= '0;
      stp_q <= '0;
      ctl_q <= '0;
      pwrOn_q <= 1'b0;
    end else if (ce) begin
      pst_q <= pst_d;
      if (pnlOe) pwrReq_q <= pwrReq;
      if (reqUp || reqDn) begin
        frm_q <= '0;
        stp_q <= '0;
      end else if (stepDue) begin
        frm_q <= '0;
        stp_q <= seqDone ? '0 : stp_q + 1'b1;
        if (pst_q == PS_UP) ctl_q[stp_q] <= 1'b1;
        if (pst_q == PS_DOWN) ctl_q[VWO_PWR_STEPS-1-stp_q] <= 1'b0;
      end else if (vsRise && (pst_q == PS_UP || pst_q == PS_DOWN)) begin
        frm_q <= frm_q + 1'b1;
      end
      if (seqDone && pst_q == PS_UP) pwrOn_q <= 1'b1;
      if (seqDone && pst_q == PS_DOWN) pwrOn_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  logic dacBlank, pnlLive, hsAct, vsAct;
  assign dacBlank = !dacBlEn || blankIn;
  assign pnlLive = pnlOe && pwrOn_q && pst_q == PS_ON;
  assign hsAct = crtRun && hsEn && hsyncIn;
  assign vsAct = crtRun && vsEn && vsyncIn;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crtHsync <= 1'b0;
      crtVsync <= 1'b0;
      crtDacBlank <= 1'b1;
      mixPixel <= '0;
      panelData <= '0;
      panelDataEn <= 1'b0;
      panelPowerCtl <= '0;
      srcX <= '0;
      srcY <= '0;
      keyAsYuv <= 1'b0;
    end else if (ce) begin
      crtHsync <= hsAct ^ hsPol;
      crtVsync <= vsAct ^ vsPol;
      crtDacBlank <= dacBlank;
      mixPixel <= showVideo ? vidPixel : gfxPixel;
      panelData <= (pnlLive && !dacBlank) ?
                   (showVideo ? vidPixel : gfxPixel) : '0;
      panelDataEn <= pnlLive && !blankIn;
      panelPowerCtl <= pnlOe ? ctl_q : '0;
      srcX <= hIf.srcIdx;
      srcY <= vIf.srcIdx;
      keyAsYuv <= yuvKey;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_hsync_idle_level: assert property (@(posedge clk) disable iff (!arst_n)
    ce && !hsEn |=> crtHsync == $past(hsPol))
    else $error("hsync not at idle level while disabled");
  a_vsync_idle_level: assert property (@(posedge clk) disable iff (!arst_n)
    ce && !vsEn |=> crtVsync == $past(vsPol))
    else $error("vsync not at idle level while disabled");
  a_hsync_polarity: assert property (@(posedge clk) disable iff (!arst_n)
    ce && hsAct |=> crtHsync == !$past(hsPol))
    else $error("hsync active level wrong");
  a_dac_always_blank: assert property (@(posedge clk) disable iff (!arst_n)
    ce && !dacBlEn |=> crtDacBlank)
    else $error("dac not blanked");
  a_panel_zero_off: assert property (@(posedge clk) disable iff (!arst_n)
    ce && !pwrOn_q |=> panelData == '0 && !panelDataEn)
    else $error("panel data before power up");
  a_crt_held_reset: assert property (@(posedge clk) disable iff (!arst_n)
    ce && !crtRun |=> hCnt_q == '0 && vCnt_q == '0)
    else $error("crt counters run in reset");
  a_flag_only_done: assert property (@(posedge clk) disable iff (!arst_n)
    ce && !seqDone |=> $stable(pwrOn_q))
    else $error("power flag moved without sequence end");
  a_req_ignored_off: assert property (@(posedge clk) disable iff (!arst_n)
    !pnlOe && pst_q == PS_OFF |-> pst_d == PS_OFF)
    else $error("power request acted on while output disabled");
  a_window_excl_end: assert property (@(posedge clk) disable iff (!arst_n)
    hCnt_q == winHEnd |-> !inWin)
    else $error("window includes horizontal end");
endmodule

// >>> tb/vwo_display_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Display at the far side of the sync and panel lines
// ---------------------------------------------------------------
module vwo_display_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Sync and panel lines
  input wire logic hsync,
  input wire logic hsyncPol,
  input wire logic [23:0] pnlData,
  input wire logic [2:0] pwrCtl,
  // Observations
  output int syncSeen,
  output int earlyData
);
  logic active_q;
  wire logic active;

  assign active = hsync ^ hsyncPol;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= 1'h0;
      syncSeen <= 0;
      earlyData <= 0;
    end else begin
      active_q <= active;
      if (active && !active_q) begin
        syncSeen <= syncSeen + 1;
      end
      // A panel that is not fully powered must never see pixel data.
      if (pwrCtl !== 3'h7 && pnlData !== 24'h0) begin
        earlyData <= earlyData + 1;
      end
    end
  end
endmodule

// >>> tb/video_window_overlay_ctrl_tb_top.sv
`timescale 1ns/1ns
module video_window_overlay_ctrl_tb_top;
  import vwo_pkg::*;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic regWr = 1'h0;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic hsyncIn = 1'h0;
  logic vsyncIn = 1'h0;
  logic blankIn = 1'h0;
  logic hsPol = 1'h0;
  logic [23:0] gfxPixel = 24'h0;
  logic [23:0] vidPixel = 24'h0;
  logic crtHsync, crtVsync, crtDacBlank, panelDataEn, keyAsYuv;
  logic [23:0] mixPixel, panelData;
  logic [2:0] panelPowerCtl;
  logic [11:0] srcX, srcY;
  logic [31:0] r;
  logic [31:0] cfg;
  int syncSeen, earlyData, n0;
  int fails = 0;
  int compares = 0;
  logic [7:0] ofs [7] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h4C, 8'h40};

  always #2 clk = ~clk;

  vwo_overlay_ctrl i_dut (.clk(clk), .arst_n(arst_n), .ce(1'h1),
    .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .hsyncIn(hsyncIn), .vsyncIn(vsyncIn),
    .blankIn(blankIn), .gfxPixel(gfxPixel), .vidPixel(vidPixel),
    .crtHsync(crtHsync), .crtVsync(crtVsync), .crtDacBlank(crtDacBlank),
    .mixPixel(mixPixel), .panelData(panelData),
    .panelDataEn(panelDataEn), .panelPowerCtl(panelPowerCtl),
    .srcX(srcX), .srcY(srcY), .keyAsYuv(keyAsYuv));

  vwo_display_model i_disp (.clk(clk), .arst_n(arst_n), .hsync(crtHsync),
    .hsyncPol(hsPol), .pnlData(panelData), .pwrCtl(panelPowerCtl),
    .syncSeen(syncSeen), .earlyData(earlyData));

  // ---------------------------------------------------------------
  // Access and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    regWr = 1'h1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWr = 1'h0;
    repeat (2) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    r = regRdata;
  endtask

  task automatic hpulse();
    hsyncIn = 1'h1;
    repeat (2) @(negedge clk);
    hsyncIn = 1'h0;
    repeat (3) @(negedge clk);
  endtask

  task automatic vpulse();
    vsyncIn = 1'h1;
    repeat (2) @(negedge clk);
    vsyncIn = 1'h0;
    repeat (3) @(negedge clk);
  endtask

  task automatic mix(input logic [23:0] g, v, e);
    gfxPixel = g;
    vidPixel = v;
    hpulse();
    chk("mixPixel", {8'h0, mixPixel}, {8'h0, e});
  endtask

  task automatic summarize();
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    chk("dacBlankRst", {31'h0, crtDacBlank}, 32'h1);
    arst_n = 1'h1;
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i]);
      chk("resetValue", r, i == 5 ? VWO_RST_MIXCTL : VWO_RST_ZERO);
    end
    chk("keyAsYuv", {31'h0, keyAsYuv}, 32'h1);
    wr(VWO_OFS_XPOS, 32'h0ABC0123);
    rd(VWO_OFS_XPOS);
    chk("xPos", r, 32'h0ABC0123);
    wr(VWO_OFS_YPOS, 32'h04560321);
    rd(VWO_OFS_YPOS);
    chk("yPos", r, 32'h04560321);
    wr(VWO_OFS_SCALE, 32'h10002000);
    rd(VWO_OFS_SCALE);
    chk("scale", r, 32'h10002000);
    for (int p = 0; p < 2; p++) begin
      for (int e = 0; e < 2; e++) begin
        cfg = 32'hD;
        cfg[VWO_B_HS_EN] = e[0];
        cfg[VWO_B_HS_POL] = p[0];
        hsPol = p[0];
        wr(VWO_OFS_DISPCFG, cfg);
        n0 = syncSeen;
        hsyncIn = 1'h1;
        repeat (2) @(negedge clk);
        chk("hsActive", {31'h0, crtHsync}, {31'h0, p[0] ^ e[0]});
        hsyncIn = 1'h0;
        repeat (2) @(negedge clk);
        chk("hsIdle", {31'h0, crtHsync}, {31'h0, p[0]});
        chk("hsCount", syncSeen - n0, e);
      end
    end
    hsPol = 1'h0;
    wr(VWO_OFS_DISPCFG, 32'h6);
    hsyncIn = 1'h1;
    vsyncIn = 1'h1;
    repeat (2) @(negedge clk);
    chk("crtHeldReset", {30'h0, crtHsync, crtVsync}, 32'h0);
    wr(VWO_OFS_DISPCFG, 32'h3);
    chk("vsOff", {30'h0, crtHsync, crtVsync}, 32'h2);
    wr(VWO_OFS_DISPCFG, 32'h5);
    chk("vsOn", {30'h0, crtHsync, crtVsync}, 32'h1);
    chk("dacAlways", {31'h0, crtDacBlank}, 32'h1);
    hsyncIn = 1'h0;
    vsyncIn = 1'h0;
    wr(VWO_OFS_DISPCFG, 32'h9);
    chk("dacActive", {31'h0, crtDacBlank}, 32'h0);
    blankIn = 1'h1;
    repeat (2) @(negedge clk);
    chk("dacBlanked", {31'h0, crtDacBlank}, 32'h1);
    blankIn = 1'h0;
    wr(VWO_OFS_XPOS, 32'h0FFF0000);
    wr(VWO_OFS_YPOS, 32'h07FF0000);
    wr(VWO_OFS_KEY, 32'h00123456);
    wr(VWO_OFS_MASK, 32'h00FFFF00);
    vpulse();
    mix(24'h1234AB, 24'hABCDEF, 24'hABCDEF);
    // Unity step: three window pixels into the line give source index 3.
    chk("srcXUnity", {20'h0, srcX}, 32'h3);
    mix(24'h1235AB, 24'hABCDEF, 24'h1235AB);
    // Half step: the third window line, two hsyncs after vsync, maps to source line 1.
    chk("srcYHalf", {20'h0, srcY}, 32'h1);
    wr(VWO_OFS_DISPCFG, 32'h00100009);
    mix(24'h111111, 24'h123400, 24'h111111);
    mix(24'h111111, 24'h993456, 24'h993456);
    wr(VWO_OFS_XPOS, 32'h0);
    mix(24'h111111, 24'h993456, 24'h111111);
    wr(VWO_OFS_MIXCTL, 32'h00062000);
    chk("keyRgbSel", {31'h0, keyAsYuv}, 32'h0);
    wr(VWO_OFS_MIXCTL, 32'h00060400);
    chk("keyRgbCsc", {31'h0, keyAsYuv}, 32'h0);
    gfxPixel = 24'h5A5A5A;
    wr(VWO_OFS_DISPCFG, 32'h00000049);
    repeat (4) vpulse();
    chk("pnlOff", {5'h0, panelPowerCtl, panelData}, 32'h0);
    wr(VWO_OFS_DISPCFG, 32'h00040089);
    wr(VWO_OFS_DISPCFG, 32'h000400C9);
    vpulse();
    rd(VWO_OFS_DISPCFG);
    chk("flagEarly", {31'h0, r[VWO_B_PWR_FLAG]}, 32'h0);
    chk("stepSpacing", {29'h0, panelPowerCtl}, 32'h0);
    vpulse();
    chk("firstStep", {29'h0, panelPowerCtl}, 32'h1);
    vpulse();
    chk("stepHeld", {29'h0, panelPowerCtl}, 32'h1);
    vpulse();
    chk("secondStep", {29'h0, panelPowerCtl}, 32'h3);
    for (int i = 0; i < 12 && panelPowerCtl !== 3'h7; i++) vpulse();
    rd(VWO_OFS_DISPCFG);
    chk("poweredUp", {r[VWO_B_PWR_FLAG], panelPowerCtl}, 32'hF);
    chk("pnlData", {7'h0, panelDataEn, panelData}, 32'h015A5A5A);
    blankIn = 1'h1;
    repeat (2) @(negedge clk);
    chk("pnlBlank", {7'h0, panelDataEn, panelData}, 32'h0);
    blankIn = 1'h0;
    wr(VWO_OFS_DISPCFG, 32'h00040089);
    for (int i = 0; i < 12 && panelPowerCtl !== 3'h0; i++) vpulse();
    rd(VWO_OFS_DISPCFG);
    chk("poweredDown", {r[VWO_B_PWR_FLAG], panelPowerCtl}, 32'h0);
    chk("earlyData", earlyData, 32'h0);
    summarize();
  end

  // A hang would otherwise stall the run with no verdict.
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule
